// *** logic/fbs_pkg.sv ***
// shared constants and types for the fieldbus slave state and parameter block
package fbs_pkg;
   // requested / current communication states (gray along startup->pre->safe->run)
   typedef enum logic [2:0] {
      ST_STARTUP  = 3'h0,
      ST_MAILBOX  = 3'h1,
      ST_GUARDED  = 3'h3,
      ST_FULL_RUN = 3'h2,
      ST_FW_BOOT  = 3'h6
   } fbs_state_e;

   // dictionary index ranges
   localparam logic [15:0] IDX_IDENTITY   = 16'h1000;
   localparam logic [15:0] IDX_LEGACY_CH  = 16'h4000;
   localparam logic [15:0] IDX_INPUT_OBJ  = 16'h6000;
   localparam logic [15:0] IDX_OUTPUT_OBJ = 16'h7000;
   localparam logic [15:0] IDX_CHAN_BASE  = 16'h8000;
   localparam logic [15:0] IDX_SKIP_CTRL  = 16'hf008;
   localparam logic [31:0] SKIP_CODE      = 32'h12345678;
   localparam int          CHAN_STRIDE    = 16;
   localparam int          IDX_HI_POS     = 12;

   // parameter access answer codes
   localparam logic [1:0] ACC_OK      = 2'h0;
   localparam logic [1:0] ACC_RDONLY  = 2'h1;
   localparam logic [1:0] ACC_NOOBJ   = 2'h2;

   // reset values
   localparam logic [31:0] PARAM_RESET = 32'h00000000;
endpackage

// *** logic/fbs_param_store.sv ***
// per-channel parameter store with mirrored legacy range and persist request
`timescale 1ns/1ps
`default_nettype none
module fbs_param_store #(
   parameter int CHANNELS = 4
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // access request
   input  wire logic        req,
   input  wire logic        wr,
   input  wire logic [15:0] index,
   input  wire logic [7:0]  subindex,
   input  wire logic [31:0] wdata,
   // answer
   output logic             ack,
   output logic [1:0]       status,
   output logic [31:0]      rdata,
   output logic             persist,
   output logic             skip_mode
);
   localparam int SLOTS = CHANNELS * fbs_pkg::CHAN_STRIDE;

   logic [31:0] mem_reg [SLOTS];
   logic [31:0] mem_next [SLOTS];
   logic        ack_reg, ack_next, per_reg, per_next, skip_reg, skip_next;
   logic [1:0]  st_reg, st_next;
   logic [31:0] rd_reg, rd_next;
   logic        in_chan, in_legacy, hit;
   logic [15:0] slot;

   // legacy 0x4000 area maps onto the same storage as 0x8000, so both stay consistent
   always_comb begin
      in_chan   = (index[15:12] == fbs_pkg::IDX_CHAN_BASE[15:12]);
      in_legacy = (index[15:12] == fbs_pkg::IDX_LEGACY_CH[15:12]);
      slot      = {4'h0, index[11:0]};
      hit       = (in_chan || in_legacy) && (32'(slot) < 32'(SLOTS)) && (subindex == 8'h00);
   end

   // access handling: fixed areas read-only, channel area read-write
   always_comb begin
      mem_next  = mem_reg;
      ack_next  = req;
      per_next  = 1'b0;
      skip_next = skip_reg;
      st_next   = fbs_pkg::ACC_OK;
      rd_next   = rd_reg;
      if (req) begin
         if (index == fbs_pkg::IDX_SKIP_CTRL) begin
            if (wr) skip_next = (wdata == fbs_pkg::SKIP_CODE);
            rd_next = {31'h0, skip_reg};
         end else if (hit) begin
            rd_next = mem_reg[slot[$clog2(SLOTS)-1:0]];
            if (wr) begin
               mem_next[slot[$clog2(SLOTS)-1:0]] = wdata;
               per_next = !skip_reg;
            end
         end else if (index[15:12] == fbs_pkg::IDX_IDENTITY[15:12]
                      || index[15:12] == fbs_pkg::IDX_INPUT_OBJ[15:12]
                      || index[15:12] == fbs_pkg::IDX_OUTPUT_OBJ[15:12]) begin
            // fixed and process objects are read-only over the dictionary
            rd_next = {index, 8'h00, subindex};
            if (wr) st_next = fbs_pkg::ACC_RDONLY;
         end else begin
            st_next = fbs_pkg::ACC_NOOBJ;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < SLOTS; i++) mem_reg[i] <= fbs_pkg::PARAM_RESET;
         ack_reg  <= 1'b0;
         per_reg  <= 1'b0;
         skip_reg <= 1'b0;
         st_reg   <= fbs_pkg::ACC_OK;
         rd_reg   <= 32'h0;
      end else begin
         mem_reg  <= mem_next;
         ack_reg  <= ack_next;
         per_reg  <= per_next;
         skip_reg <= skip_next;
         st_reg   <= st_next;
         rd_reg   <= rd_next;
      end
   end

   assign ack       = ack_reg;
   assign status    = st_reg;
   assign rdata     = rd_reg;
   assign persist   = per_reg;
   assign skip_mode = skip_reg;

   // any write into the fixed identity area must be refused, not only its first index
   a_fixed_rdonly: assert property (@(posedge clk) disable iff (!rst_n)
      req && wr && index[15:12] == fbs_pkg::IDX_IDENTITY[15:12]
      |=> status == fbs_pkg::ACC_RDONLY && !persist)
      else $error("fixed object write not refused");
   a_skip_blocks: assert property (@(posedge clk) disable iff (!rst_n)
      skip_mode && !(req && index == fbs_pkg::IDX_SKIP_CTRL) |=> !persist)
      else $error("persist while skip mode");
   a_persist_wr: assert property (@(posedge clk) disable iff (!rst_n)
      req && wr && hit && !skip_mode |=> persist)
      else $error("channel write not persisted");
   c_skip_on: cover property (@(posedge clk) disable iff (!rst_n) $rose(skip_mode));
endmodule
`default_nettype wire

// *** logic/fbs_slave_core.sv ***
// communication state machine and traffic gating of the fieldbus slave
`timescale 1ns/1ps
`default_nettype none
module fbs_slave_core #(
   parameter int DATA_W   = 8,
   parameter int CHANNELS = 4
) (
   // clock and reset
   input  wire logic              CORE_CLK,
   input  wire logic              RESETN,
   // state request from the master
   input  wire logic              STATE_REQ,
   input  wire logic [2:0]        STATE_TARGET,
   input  wire logic              MAILBOX_CFG_OK,
   input  wire logic              PROC_CFG_OK,
   input  wire logic              CLOCK_CFG_OK,
   input  wire logic              WATCHDOG_OFF,
   // traffic offered by the master
   input  wire logic              MBX_REQ,
   input  wire logic              MBX_IS_FILE,
   input  wire logic              PROC_REQ,
   input  wire logic [DATA_W-1:0] OUT_DATA,
   // local inputs of the terminal
   input  wire logic [DATA_W-1:0] FIELD_IN,
   // dictionary access
   input  wire logic              PAR_REQ,
   input  wire logic              PAR_WR,
   input  wire logic [15:0]       PAR_INDEX,
   input  wire logic [7:0]        PAR_SUBINDEX,
   input  wire logic [31:0]       PAR_WDATA,
   // state answers
   output logic [2:0]             STATE_NOW,
   output logic                   STATE_ACK,
   output logic                   STATE_NAK,
   // traffic answers
   output logic                   MBX_GRANT,
   output logic                   MBX_REFUSE,
   output logic                   PROC_GRANT,
   output logic                   PROC_REFUSE,
   // dual-port memory input image and field outputs
   output logic [DATA_W-1:0]      DPM_IN_DATA,
   output logic                   DPM_IN_WE,
   output logic [DATA_W-1:0]      FIELD_OUT,
   // dictionary answers
   output logic                   PAR_ACK,
   output logic [1:0]             PAR_STATUS,
   output logic [31:0]            PAR_RDATA,
   output logic                   PERSIST_REQ,
   output logic                   SKIP_PERSIST
);
   fbs_pkg::fbs_state_e st_reg, st_next;
   logic ack_reg, ack_next, nak_reg, nak_next;
   logic mg_reg, mg_next, mr_reg, mr_next, pg_reg, pg_next, pr_reg, pr_next;
   logic [DATA_W-1:0] dpm_reg, dpm_next, out_reg, out_next;
   logic dwe_reg, dwe_next;
   logic allowed, checks_ok, mbx_ok, proc_ok;
   fbs_pkg::fbs_state_e tgt;

   // decide whether the requested transition is permitted and passes its checks
   // boot entry also needs a valid mailbox, since file transfer runs over it
   always_comb begin
      tgt       = fbs_pkg::fbs_state_e'(STATE_TARGET);
      allowed   = 1'b0;
      checks_ok = 1'b1;
      case (st_reg)
         fbs_pkg::ST_STARTUP: begin
            if (tgt == fbs_pkg::ST_MAILBOX) begin
               allowed   = 1'b1;
               checks_ok = MAILBOX_CFG_OK;
            end
            if (tgt == fbs_pkg::ST_FW_BOOT) begin
               allowed   = 1'b1;
               checks_ok = MAILBOX_CFG_OK;
            end
         end
         fbs_pkg::ST_MAILBOX: begin
            if (tgt == fbs_pkg::ST_GUARDED) begin
               allowed   = 1'b1;
               checks_ok = PROC_CFG_OK && CLOCK_CFG_OK;
            end
            if (tgt == fbs_pkg::ST_STARTUP) allowed = 1'b1;
         end
         fbs_pkg::ST_GUARDED: begin
            // master is trusted to have delivered valid output data before this
            if (tgt == fbs_pkg::ST_FULL_RUN) allowed = 1'b1;
            if (tgt == fbs_pkg::ST_MAILBOX || tgt == fbs_pkg::ST_STARTUP) allowed = 1'b1;
         end
         fbs_pkg::ST_FULL_RUN: begin
            if (tgt != fbs_pkg::ST_FW_BOOT && tgt != fbs_pkg::ST_FULL_RUN) allowed = 1'b1;
         end
         fbs_pkg::ST_FW_BOOT: begin
            if (tgt == fbs_pkg::ST_STARTUP) allowed = 1'b1;
         end
         default: allowed = 1'b0;
      endcase
   end

   // state register update; a refused request keeps the state
   // a refused request answers with a nak so the master never waits on a silent block
   always_comb begin
      st_next  = st_reg;
      ack_next = 1'b0;
      nak_next = 1'b0;
      if (STATE_REQ) begin
         if (allowed && checks_ok) begin
            st_next  = tgt;
            ack_next = 1'b1;
         end else begin
            nak_next = 1'b1;
         end
      end
   end

   // traffic permitted per state
   // boot lets only file transfer through so an image load cannot be disturbed
   always_comb begin
      mbx_ok  = 1'b0;
      proc_ok = 1'b0;
      case (st_reg)
         fbs_pkg::ST_STARTUP:  begin mbx_ok = 1'b0; proc_ok = 1'b0; end
         fbs_pkg::ST_MAILBOX:  begin mbx_ok = 1'b1; proc_ok = 1'b0; end
         fbs_pkg::ST_GUARDED:  begin mbx_ok = 1'b1; proc_ok = 1'b1; end
         fbs_pkg::ST_FULL_RUN: begin mbx_ok = 1'b1; proc_ok = 1'b1; end
         fbs_pkg::ST_FW_BOOT:  begin mbx_ok = MBX_IS_FILE; proc_ok = 1'b0; end
         default:              begin mbx_ok = 1'b0; proc_ok = 1'b0; end
      endcase
      mg_next = MBX_REQ && mbx_ok;
      mr_next = MBX_REQ && !mbx_ok;
      pg_next = PROC_REQ && proc_ok;
      pr_next = PROC_REQ && !proc_ok;
   end

   // input image and output data handling
   // limitation: outputs hold between process data cycles; watchdog timing is not kept here
   always_comb begin
      dpm_next = dpm_reg;
      dwe_next = 1'b0;
      out_next = out_reg;
      // snapshot inputs on the edge into guarded run, seen in the same cycle as its ack
      if (STATE_REQ && allowed && checks_ok && tgt == fbs_pkg::ST_GUARDED) begin
         dpm_next = FIELD_IN;
         dwe_next = 1'b1;
      end else if (st_reg == fbs_pkg::ST_GUARDED || st_reg == fbs_pkg::ST_FULL_RUN) begin
         dpm_next = FIELD_IN;
         dwe_next = 1'b1;
      end
      if (st_reg == fbs_pkg::ST_FULL_RUN) begin
         if (PROC_REQ) out_next = OUT_DATA;
      end else if (st_reg == fbs_pkg::ST_GUARDED && WATCHDOG_OFF) begin
         // watchdog supervision off: outputs follow the master already here
         if (PROC_REQ) out_next = OUT_DATA;
      end else begin
         out_next = '0;
      end
   end

   // registers of the state machine and ports
   // async reset lands in startup, so traffic is refused from the first edge after release
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         st_reg  <= fbs_pkg::ST_STARTUP;
         ack_reg <= 1'b0;
         nak_reg <= 1'b0;
         mg_reg  <= 1'b0;
         mr_reg  <= 1'b0;
         pg_reg  <= 1'b0;
         pr_reg  <= 1'b0;
         dpm_reg <= '0;
         dwe_reg <= 1'b0;
         out_reg <= '0;
      end else begin
         st_reg  <= st_next;
         ack_reg <= ack_next;
         nak_reg <= nak_next;
         mg_reg  <= mg_next;
         mr_reg  <= mr_next;
         pg_reg  <= pg_next;
         pr_reg  <= pr_next;
         dpm_reg <= dpm_next;
         dwe_reg <= dwe_next;
         out_reg <= out_next;
      end
   end

   assign STATE_NOW   = st_reg;
   assign STATE_ACK   = ack_reg;
   assign STATE_NAK   = nak_reg;
   assign MBX_GRANT   = mg_reg;
   assign MBX_REFUSE  = mr_reg;
   assign PROC_GRANT  = pg_reg;
   assign PROC_REFUSE = pr_reg;
   assign DPM_IN_DATA = dpm_reg;
   assign DPM_IN_WE   = dwe_reg;
   assign FIELD_OUT   = out_reg;

   // parameter dictionary (outputs registered inside)
   fbs_param_store #(
      .CHANNELS (CHANNELS)
   ) u_store (
      .clk       (CORE_CLK),
      .rst_n     (RESETN),
      .req       (PAR_REQ),
      .wr        (PAR_WR),
      .index     (PAR_INDEX),
      .subindex  (PAR_SUBINDEX),
      .wdata     (PAR_WDATA),
      .ack       (PAR_ACK),
      .status    (PAR_STATUS),
      .rdata     (PAR_RDATA),
      .persist   (PERSIST_REQ),
      .skip_mode (SKIP_PERSIST)
   );

   // checks on the state machine
   a_startup_quiet: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      st_reg == fbs_pkg::ST_STARTUP && (MBX_REQ || PROC_REQ) |=> !MBX_GRANT && !PROC_GRANT)
      else $error("traffic granted in startup");
   a_mbx_check: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      st_reg == fbs_pkg::ST_STARTUP && STATE_REQ && !MAILBOX_CFG_OK |=> STATE_NAK
      && STATE_NOW == fbs_pkg::ST_STARTUP)
      else $error("bad mailbox accepted");
   a_pre_no_proc: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      st_reg == fbs_pkg::ST_MAILBOX && PROC_REQ |=> PROC_REFUSE && !PROC_GRANT)
      else $error("process data in mailbox-only state");
   a_guard_check: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      st_reg == fbs_pkg::ST_MAILBOX && STATE_REQ && tgt == fbs_pkg::ST_GUARDED
      && !(PROC_CFG_OK && CLOCK_CFG_OK) |=> STATE_NOW == fbs_pkg::ST_MAILBOX)
      else $error("guarded run without valid setup");
   a_snapshot: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      $rose(STATE_NOW == fbs_pkg::ST_GUARDED) |-> DPM_IN_WE && STATE_ACK)
      else $error("no input snapshot at guarded entry");
   a_safe_out: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      st_reg == fbs_pkg::ST_GUARDED && !WATCHDOG_OFF |=> FIELD_OUT == '0)
      else $error("outputs live in guarded run");
   a_run_copy: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      st_reg == fbs_pkg::ST_FULL_RUN && PROC_REQ |=> FIELD_OUT == $past(OUT_DATA))
      else $error("output data not copied");
   a_boot_entry: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      st_reg != fbs_pkg::ST_STARTUP && st_reg != fbs_pkg::ST_FW_BOOT |=>
      STATE_NOW != fbs_pkg::ST_FW_BOOT)
      else $error("boot entered from wrong state");
   a_boot_file: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      st_reg == fbs_pkg::ST_FW_BOOT && MBX_REQ && !MBX_IS_FILE |=> MBX_REFUSE ##0 !PROC_GRANT)
      else $error("non-file mailbox in boot");
   a_nak_hold: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      STATE_REQ && !(allowed && checks_ok) |=> STATE_NOW == $past(st_reg) && !STATE_ACK)
      else $error("refused request changed state");
   a_ack_move: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      STATE_REQ && allowed && checks_ok
      |=> STATE_ACK && !STATE_NAK && STATE_NOW == $past(tgt))
      else $error("accepted request not acknowledged");

   // grants per state: a wrong decode here would leak process data too early
   a_mbx_gate: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      st_reg == fbs_pkg::ST_MAILBOX && MBX_REQ |=> MBX_GRANT && !MBX_REFUSE)
      else $error("mailbox refused in mailbox-only state");
   a_guard_grant: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      st_reg == fbs_pkg::ST_GUARDED && MBX_REQ && PROC_REQ |=> MBX_GRANT && PROC_GRANT)
      else $error("traffic refused in guarded run");
   a_run_grant: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      st_reg == fbs_pkg::ST_FULL_RUN && MBX_REQ && PROC_REQ |=> MBX_GRANT && PROC_GRANT)
      else $error("traffic refused in full run");
   a_boot_nopd: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      st_reg == fbs_pkg::ST_FW_BOOT && PROC_REQ |=> PROC_REFUSE && !PROC_GRANT)
      else $error("process data in boot");
   a_boot_fgrant: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      st_reg == fbs_pkg::ST_FW_BOOT && MBX_REQ && MBX_IS_FILE |=> MBX_GRANT && !MBX_REFUSE)
      else $error("file transfer refused in boot");

   // input image and output follow checks
   a_in_refresh: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      st_reg == fbs_pkg::ST_GUARDED || st_reg == fbs_pkg::ST_FULL_RUN
      |=> DPM_IN_WE && DPM_IN_DATA == $past(FIELD_IN))
      else $error("input image not refreshed");
   a_wd_follow: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      st_reg == fbs_pkg::ST_GUARDED && WATCHDOG_OFF && PROC_REQ
      |=> FIELD_OUT == $past(OUT_DATA))
      else $error("outputs not driven with watchdog off");

   c_reach_guard: cover property (@(posedge CORE_CLK) disable iff (!RESETN)
      $rose(STATE_NOW == fbs_pkg::ST_GUARDED));
   c_reach_run: cover property (@(posedge CORE_CLK) disable iff (!RESETN)
      $rose(STATE_NOW == fbs_pkg::ST_FULL_RUN));
   c_reach_boot: cover property (@(posedge CORE_CLK) disable iff (!RESETN)
      $rose(STATE_NOW == fbs_pkg::ST_FW_BOOT));
   c_refused: cover property (@(posedge CORE_CLK) disable iff (!RESETN) STATE_NAK);
endmodule
`default_nettype wire

// *** sim/fbs_master_model.sv ***
// master-side model that drives state, traffic and dictionary requests
`timescale 1ns/1ps
`default_nettype none
module fbs_master_model (
   // clock
   input  wire logic        clk,
   // state request and setup levels
   output logic             state_req,
   output logic [2:0]       state_target,
   output logic             mbx_cfg_ok,
   output logic             proc_cfg_ok,
   output logic             clk_cfg_ok,
   output logic             wd_off,
   // traffic
   output logic             mbx_req,
   output logic             mbx_file,
   output logic             proc_req,
   output logic [7:0]       out_data,
   // dictionary
   output logic             par_req,
   output logic             par_wr,
   output logic [15:0]      par_index,
   output logic [7:0]       par_sub,
   output logic [31:0]      par_wdata
);
   // idle bus at time zero; clock setup reported good as no sync clock is used
   initial begin
      {state_req, mbx_req, mbx_file, proc_req, par_req, par_wr} = 6'h00;
      {mbx_cfg_ok, proc_cfg_ok, wd_off} = 3'h0;
      clk_cfg_ok   = 1'h1;
      state_target = 3'h7;
      out_data     = 8'h00;
      {par_index, par_sub, par_wdata} = 56'h0;
   end

   // setup levels, process channels reported as given, whether or not the mailbox is up
   task automatic setup(input logic m, p, c, w);
      @(posedge clk);
      mbx_cfg_ok  <= m;
      proc_cfg_ok <= p;
      clk_cfg_ok  <= c;
      wd_off      <= w;
   endtask

   // one state request; target inverted afterwards so a stale value is not seen
   task automatic state(input logic [2:0] t);
      @(posedge clk);
      state_req    <= 1'h1;
      state_target <= t;
      @(posedge clk);
      state_req    <= 1'h0;
      state_target <= ~t;
      #1;
   endtask

   // one traffic cycle; output data scrambled outside the request cycle
   task automatic traffic(input logic m, f, p, input logic [7:0] d);
      @(posedge clk);
      mbx_req  <= m;
      mbx_file <= f;
      proc_req <= p;
      out_data <= d;
      @(posedge clk);
      {mbx_req, proc_req} <= 2'h0;
      out_data <= ~d;
      #1;
   endtask

   // one dictionary access
   task automatic param(input logic w, input logic [15:0] i, input logic [7:0] s,
                        input logic [31:0] d);
      @(posedge clk);
      par_req   <= 1'h1;
      par_wr    <= w;
      par_index <= i;
      par_sub   <= s;
      par_wdata <= d;
      @(posedge clk);
      par_req   <= 1'h0;
      par_index <= ~i;
      par_wdata <= ~d;
      #1;
   endtask
endmodule
`default_nettype wire

// *** sim/fbs_tb.sv ***
// self-checking bench for the slave state machine and dictionary
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) begin \
         bad_count++; \
         $display("wrong value %s expected %h seen %h", name, exp, got); \
      end \
   end
module tb;
   localparam logic       Y  = 1'h1;
   localparam logic       N  = 1'h0;
   localparam logic [2:0] SU = fbs_pkg::ST_STARTUP;
   localparam logic [2:0] MB = fbs_pkg::ST_MAILBOX;
   localparam logic [2:0] GR = fbs_pkg::ST_GUARDED;
   localparam logic [2:0] FR = fbs_pkg::ST_FULL_RUN;
   localparam logic [2:0] BT = fbs_pkg::ST_FW_BOOT;
   localparam logic [1:0] OK = fbs_pkg::ACC_OK;
   // clock, reset, local inputs and counters
   logic        core_clk = 1'h0;
   logic        resetn   = 1'h0;
   logic [7:0]  field_in = 8'h00;
   int          bad_count = 0;
   int          samples_checked = 0;
   // master side
   wire logic   s_req, m_ok, p_ok, c_ok, wd_off, mbx_req, mbx_file, proc_req, par_req, par_wr;
   wire logic [2:0]  s_tgt;
   wire logic [7:0]  out_data, par_sub;
   wire logic [15:0] par_index;
   wire logic [31:0] par_wdata;
   // block answers
   logic [2:0]  state_now;
   logic        s_ack, s_nak, mbx_gnt, mbx_ref, proc_gnt, proc_ref, dpm_we, par_ack, persist;
   logic [7:0]  dpm_data, field_out;
   logic [1:0]  par_st;
   logic        skip_on;
   logic [31:0] par_rd;

   // 10 MHz core clock
   always #50 core_clk = ~core_clk;

   fbs_master_model m (.clk(core_clk), .state_req(s_req), .state_target(s_tgt),
      .mbx_cfg_ok(m_ok), .proc_cfg_ok(p_ok), .clk_cfg_ok(c_ok), .wd_off(wd_off),
      .mbx_req(mbx_req), .mbx_file(mbx_file), .proc_req(proc_req), .out_data(out_data),
      .par_req(par_req), .par_wr(par_wr), .par_index(par_index), .par_sub(par_sub),
      .par_wdata(par_wdata));

   fbs_slave_core #(.DATA_W(8), .CHANNELS(4)) uut (.CORE_CLK(core_clk), .RESETN(resetn),
      .STATE_REQ(s_req), .STATE_TARGET(s_tgt), .MAILBOX_CFG_OK(m_ok), .PROC_CFG_OK(p_ok),
      .CLOCK_CFG_OK(c_ok), .WATCHDOG_OFF(wd_off), .MBX_REQ(mbx_req), .MBX_IS_FILE(mbx_file),
      .PROC_REQ(proc_req), .OUT_DATA(out_data), .FIELD_IN(field_in), .PAR_REQ(par_req),
      .PAR_WR(par_wr), .PAR_INDEX(par_index), .PAR_SUBINDEX(par_sub), .PAR_WDATA(par_wdata),
      .STATE_NOW(state_now), .STATE_ACK(s_ack), .STATE_NAK(s_nak), .MBX_GRANT(mbx_gnt),
      .MBX_REFUSE(mbx_ref), .PROC_GRANT(proc_gnt), .PROC_REFUSE(proc_ref),
      .DPM_IN_DATA(dpm_data), .DPM_IN_WE(dpm_we), .FIELD_OUT(field_out), .PAR_ACK(par_ack),
      .PAR_STATUS(par_st), .PAR_RDATA(par_rd), .PERSIST_REQ(persist), .SKIP_PERSIST(skip_on));

   // state request with expected answer and resulting state
   task automatic go(input logic [2:0] t, input logic ok, input logic [2:0] now);
      m.state(t);
      `CHK("state ack", ok, s_ack)
      `CHK("state nak", ~ok, s_nak)
      `CHK("state now", now, state_now)
   endtask

   // traffic cycle with expected grants
   task automatic tx(input logic mb, fl, pr, input logic [7:0] d, input logic gm, gp);
      m.traffic(mb, fl, pr, d);
      `CHK("mbx grant", mb & gm, mbx_gnt)
      `CHK("mbx refuse", mb & ~gm, mbx_ref)
      `CHK("proc grant", pr & gp, proc_gnt)
      `CHK("proc refuse", pr & ~gp, proc_ref)
   endtask

   // dictionary access; write data echo of the skip object is left open
   task automatic pa(input logic w, input logic [15:0] i, input logic [7:0] s,
                     input logic [31:0] d, input logic [1:0] st, input logic [31:0] rd,
                     input logic ps);
      m.param(w, i, s, d);
      `CHK("param ack", Y, par_ack)
      `CHK("param status", st, par_st)
      if (st === OK && (!w || i[15:12] != 4'hf)) `CHK("param data", rd, par_rd)
      `CHK("persist", ps, persist)
   endtask

   task automatic sc_startup();
      `CHK("reset state", SU, state_now)
      tx(Y, N, Y, 8'h11, N, N);
      go(GR, N, SU);
      go(FR, N, SU);
      go(MB, N, SU);
   endtask

   task automatic sc_mailbox();
      m.setup(Y, N, Y, N);
      go(MB, Y, MB);
      tx(Y, N, Y, 8'h22, Y, N);
      go(BT, N, MB);
      go(GR, N, MB);
      m.setup(Y, Y, N, N);
      go(GR, N, MB);
   endtask

   task automatic sc_guarded();
      m.setup(Y, Y, Y, N);
      @(posedge core_clk) field_in <= 8'ha5;
      go(GR, Y, GR);
      `CHK("image write", Y, dpm_we)
      `CHK("image data", 8'ha5, dpm_data)
      @(posedge core_clk) field_in <= 8'h5a;
      @(posedge core_clk);
      #1;
      `CHK("image refresh", 8'h5a, dpm_data)
      tx(Y, N, Y, 8'h3c, Y, Y);
      `CHK("safe output", 8'h00, field_out)
      m.setup(Y, Y, Y, Y);
      tx(N, N, Y, 8'h66, N, Y);
      `CHK("unguarded output", 8'h66, field_out)
      m.setup(Y, Y, Y, N);
      tx(N, N, Y, 8'h77, N, Y);
      `CHK("safe again", 8'h00, field_out)
   endtask

   task automatic sc_full();
      go(FR, Y, FR);
      tx(Y, N, Y, 8'h81, Y, Y);
      `CHK("run output", 8'h81, field_out)
      go(BT, N, FR);
      `CHK("held output", 8'h81, field_out)
      go(SU, Y, SU);
      @(posedge core_clk);
      #1;
      `CHK("output off", 8'h00, field_out)
   endtask

   task automatic sc_boot();
      go(BT, Y, BT);
      tx(Y, Y, Y, 8'h12, Y, N);
      tx(Y, N, N, 8'h00, N, N);
      go(MB, N, BT);
      go(SU, Y, SU);
   endtask

   task automatic sc_param();
      pa(N, 16'h1000, 8'h00, 32'h0, OK, 32'h10000000, N);
      pa(Y, 16'h1018, 8'hff, 32'h1, fbs_pkg::ACC_RDONLY, 32'h0, N);
      pa(N, 16'h6000, 8'hff, 32'h0, OK, 32'h600000ff, N);
      pa(N, 16'h7000, 8'h01, 32'h0, OK, 32'h70000001, N);
      pa(N, 16'hffff, 8'h00, 32'h0, fbs_pkg::ACC_NOOBJ, 32'h0, N);
      pa(N, 16'hf008, 8'h00, 32'h0, OK, 32'h0, N);
      pa(Y, 16'h8010, 8'h00, 32'hdeadbeef, OK, fbs_pkg::PARAM_RESET, Y);
      pa(N, 16'h4010, 8'h00, 32'h0, OK, 32'hdeadbeef, N);
      pa(Y, 16'h403f, 8'h00, 32'habcd, OK, 32'h0, Y);
      pa(N, 16'h803f, 8'h00, 32'h0, OK, 32'habcd, N);
      pa(N, 16'h8040, 8'h00, 32'h0, fbs_pkg::ACC_NOOBJ, 32'h0, N);
      pa(Y, 16'hf008, 8'h00, fbs_pkg::SKIP_CODE, OK, 32'h0, N);
      pa(N, 16'hf008, 8'h00, 32'h0, OK, 32'h1, N);
      `CHK("skip mode", Y, skip_on)
      pa(Y, 16'h8000, 8'h00, 32'h5, OK, 32'h0, N);
      pa(Y, 16'hf008, 8'h00, 32'h1, OK, 32'h0, N);
      pa(Y, 16'h8000, 8'h00, 32'h6, OK, 32'h5, Y);
      // skip mode set again, then a mid-run reset must switch it off
      pa(Y, 16'hf008, 8'h00, fbs_pkg::SKIP_CODE, OK, 32'h0, N);
      @(posedge core_clk) resetn <= 1'h0;
      @(posedge core_clk) resetn <= 1'h1;
      #1;
      `CHK("skip after reset", N, skip_on)
      `CHK("state after reset", SU, state_now)
      pa(Y, 16'h8000, 8'h00, 32'h7, OK, fbs_pkg::PARAM_RESET, Y);
   endtask

   // verdict and end of run, reached from the sequence or the hang limit
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // main sequence after eight reset cycles
   initial begin
      repeat (8) @(posedge core_clk);
      resetn <= 1'h1;
      sc_startup();
      sc_mailbox();
      sc_guarded();
      sc_full();
      sc_boot();
      sc_param();
      close_out();
   end

   // hang limit; running out counts as a mismatch
   initial begin
      repeat (5000) @(posedge core_clk);
      bad_count++;
      close_out();
   end
endmodule
`default_nettype wire
